// >>> shared/rssr_pkg.sv
// Constants and types shared by the rotate, subtract, skip and return unit.
package rssr_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_IMM = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_PC = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PUSH = 8'h1C;
    localparam logic [1:0] MEM_SEL = 2'h1;

    // Field positions.
    localparam int CMD_BIT_LSB = 5;
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_SC = 4;
    localparam int FLAG_CZ = 5;
    localparam int FLAG_GIE = 6;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SKIP = 1;
    localparam int STAT_SP_LSB = 4;

    // Sizes, reset values and the interrupt entry address.
    localparam int PC_W = 12;
    localparam int MEM_DEPTH = 16;
    localparam int STACK_DEPTH = 8;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [11:0] PC_RST = 12'h000;
    localparam logic [11:0] IRQ_VECTOR = 12'h004;
    localparam logic [7:0] BYTE_ONES = 8'hFF;

    // Operation codes.
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_OR_INTO_MEMORY = 5'h01,
        OP_SUBROUTINE_EXIT = 5'h02,
        OP_SUBROUTINE_EXIT_IMM = 5'h03,
        OP_INTERRUPT_EXIT = 5'h04,
        OP_ROTATE_LEFT_IN_PLACE = 5'h05,
        OP_ROTATE_LEFT_TO_WORKING = 5'h06,
        OP_ROTATE_LEFT_VIA_FLAG = 5'h07,
        OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING = 5'h08,
        OP_ROTATE_RIGHT_IN_PLACE = 5'h09,
        OP_ROTATE_RIGHT_TO_WORKING = 5'h0A,
        OP_ROTATE_RIGHT_VIA_FLAG = 5'h0B,
        OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING = 5'h0C,
        OP_SUBTRACT_WITH_BORROW = 5'h0D,
        OP_SUBTRACT_WITH_BORROW_IMM = 5'h0E,
        OP_SUBTRACT_WITH_BORROW_TO_MEMORY = 5'h0F,
        OP_DECREMENT_SKIP_ZERO = 5'h10,
        OP_DECREMENT_SKIP_ZERO_TO_WORKING = 5'h11,
        OP_INCREMENT_SKIP_ZERO = 5'h12,
        OP_INCREMENT_SKIP_ZERO_TO_WORKING = 5'h13,
        OP_SKIP_IF_NONZERO_BIT = 5'h14,
        OP_SKIP_IF_NONZERO = 5'h15,
        OP_SET_BYTE = 5'h16,
        OP_SET_BIT = 5'h17
    } rssr_op_t;

    // Sequencer states, Gray coded along idle, exec, dummy, service.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b11,
        ST_SERVICE = 2'b10
    } rssr_state_t;

endpackage

// >>> rtl/rssr_exec.sv
// Execution unit for rotate, subtract, skip, set and return operations.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module rssr_exec
    import rssr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic irq_pending_i,
    output logic irq_taken_o,
    output logic global_irq_enable_o
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    rssr_state_t state_reg;
    rssr_op_t op_reg;
    logic [2:0] bit_reg;
    logic [3:0] addr_reg;
    logic [7:0] imm_reg;
    logic [7:0] acc_reg;
    logic [5:0] flags_reg;
    logic gie_reg;
    logic [PC_W-1:0] pc_reg;
    logic skip_reg;
    logic [3:0] sp_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic irq_taken_reg;
    logic [7:0] mem [MEM_DEPTH];
    logic [PC_W-1:0] stk [STACK_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; writes take effect at the edge that samples ack.

    wire bus_req = wb_cyc_i & wb_stb_i;
    wire idle = (state_reg == ST_IDLE);
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0] & ack_reg & idle;
    wire hit_mem = (wb_adr_i[7:6] == MEM_SEL);
    wire [3:0] mem_idx = wb_adr_i[5:2];
    wire wr_cmd = bus_wr & (wb_adr_i == OFS_CMD);
    wire wr_addr = bus_wr & (wb_adr_i == OFS_ADDR);
    wire wr_imm = bus_wr & (wb_adr_i == OFS_IMM);
    wire wr_acc = bus_wr & (wb_adr_i == OFS_ACC);
    wire wr_flags = bus_wr & (wb_adr_i == OFS_FLAGS);
    wire wr_pc = bus_wr & (wb_adr_i == OFS_PC);
    wire wr_push = bus_wr & (wb_adr_i == OFS_PUSH);
    wire wr_mem = bus_wr & hit_mem;

    // Read selection; unmapped offsets read as zero.
    wire [31:0] rd_mem = {24'h000000, mem[mem_idx]};
    wire [31:0] rd_data =
        hit_mem ? rd_mem :
        (wb_adr_i == OFS_CMD) ?
            {24'h000000, bit_reg, op_reg} :
        (wb_adr_i == OFS_ADDR) ? {28'h0000000, addr_reg} :
        (wb_adr_i == OFS_IMM) ? {24'h000000, imm_reg} :
        (wb_adr_i == OFS_ACC) ? {24'h000000, acc_reg} :
        (wb_adr_i == OFS_FLAGS) ?
            {25'h0000000, gie_reg, flags_reg} :
        (wb_adr_i == OFS_PC) ? {20'h00000, pc_reg} :
        (wb_adr_i == OFS_STATUS) ?
            {24'h000000, sp_reg, 2'b00, skip_reg, ~idle} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Operand and result datapath.

    wire [7:0] opnd = mem[addr_reg];
    wire c_old = flags_reg[FLAG_C];
    wire [7:0] rot_l = {opnd[6:0], opnd[7]};
    wire [7:0] rot_lc = {opnd[6:0], c_old};
    wire [7:0] rot_r = {opnd[0], opnd[7:1]};
    wire [7:0] rot_rc = {c_old, opnd[7:1]};
    wire [7:0] inc_val = opnd + 8'h01;
    wire [7:0] dec_val = opnd - 8'h01;
    wire [7:0] bit_mask = 8'h01 << bit_reg;
    wire [7:0] sub_src =
        (op_reg == OP_SUBTRACT_WITH_BORROW_IMM) ? imm_reg : opnd;

    // Borrow is the inverse of carry; bit 8 set means a borrow out.
    wire [8:0] sub_full = {1'b0, acc_reg} - {1'b0, sub_src}
        - {8'h00, ~c_old};
    wire [4:0] nib_full = {1'b0, acc_reg[3:0]} - {1'b0, sub_src[3:0]}
        - {4'h0, ~c_old};
    wire [7:0] sub_res = sub_full[7:0];
    wire sub_ov = (acc_reg[7] ^ sub_src[7]) & (acc_reg[7] ^ sub_res[7]);
    wire sub_z = (sub_res == 8'h00);

    // Flag image after a subtract, in register order.
    logic [5:0] sub_flags;
    always_comb begin
        sub_flags = flags_reg;
        sub_flags[FLAG_C] = ~sub_full[8];
        sub_flags[FLAG_AC] = ~nib_full[4];
        sub_flags[FLAG_Z] = sub_z;
        sub_flags[FLAG_OV] = sub_ov;
        sub_flags[FLAG_SC] = sub_res[7] ^ sub_ov;
        sub_flags[FLAG_CZ] = sub_z & flags_reg[FLAG_Z];
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation decode: what each operation writes and whether it skips.

    logic mem_we;
    logic [7:0] mem_wdata;
    logic acc_we;
    logic [7:0] acc_wdata;
    logic carry_we;
    logic carry_wdata;
    logic subf_we;
    logic skip_c;
    logic pop_c;
    logic two_cycle;
    always_comb begin
        mem_we = 1'b0;
        mem_wdata = opnd;
        acc_we = 1'b0;
        acc_wdata = acc_reg;
        carry_we = 1'b0;
        carry_wdata = c_old;
        subf_we = 1'b0;
        skip_c = 1'b0;
        pop_c = 1'b0;
        two_cycle = 1'b0;
        case (op_reg)
            OP_OR_INTO_MEMORY: begin
                mem_we = 1'b1;
                mem_wdata = opnd | acc_reg;
            end
            OP_SUBROUTINE_EXIT: begin
                pop_c = 1'b1;
                two_cycle = 1'b1;
            end
            OP_SUBROUTINE_EXIT_IMM: begin
                pop_c = 1'b1;
                two_cycle = 1'b1;
                acc_we = 1'b1;
                acc_wdata = imm_reg;
            end
            OP_INTERRUPT_EXIT: begin
                pop_c = 1'b1;
                two_cycle = 1'b1;
            end
            OP_ROTATE_LEFT_IN_PLACE: begin
                mem_we = 1'b1;
                mem_wdata = rot_l;
            end
            OP_ROTATE_LEFT_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = rot_l;
            end
            OP_ROTATE_LEFT_VIA_FLAG: begin
                mem_we = 1'b1;
                mem_wdata = rot_lc;
                carry_we = 1'b1;
                carry_wdata = opnd[7];
            end
            OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = rot_lc;
                carry_we = 1'b1;
                carry_wdata = opnd[7];
            end
            OP_ROTATE_RIGHT_IN_PLACE: begin
                mem_we = 1'b1;
                mem_wdata = rot_r;
            end
            OP_ROTATE_RIGHT_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = rot_r;
            end
            OP_ROTATE_RIGHT_VIA_FLAG: begin
                mem_we = 1'b1;
                mem_wdata = rot_rc;
                carry_we = 1'b1;
                carry_wdata = opnd[0];
            end
            OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = rot_rc;
                carry_we = 1'b1;
                carry_wdata = opnd[0];
            end
            OP_SUBTRACT_WITH_BORROW,
            OP_SUBTRACT_WITH_BORROW_IMM: begin
                acc_we = 1'b1;
                acc_wdata = sub_res;
                subf_we = 1'b1;
            end
            OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
                mem_we = 1'b1;
                mem_wdata = sub_res;
                subf_we = 1'b1;
            end
            OP_DECREMENT_SKIP_ZERO: begin
                mem_we = 1'b1;
                mem_wdata = dec_val;
                skip_c = (dec_val == 8'h00);
                two_cycle = 1'b1;
            end
            OP_DECREMENT_SKIP_ZERO_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = dec_val;
                skip_c = (dec_val == 8'h00);
                two_cycle = 1'b1;
            end
            OP_INCREMENT_SKIP_ZERO: begin
                mem_we = 1'b1;
                mem_wdata = inc_val;
                skip_c = (inc_val == 8'h00);
                two_cycle = 1'b1;
            end
            OP_INCREMENT_SKIP_ZERO_TO_WORKING: begin
                acc_we = 1'b1;
                acc_wdata = inc_val;
                skip_c = (inc_val == 8'h00);
                two_cycle = 1'b1;
            end
            OP_SKIP_IF_NONZERO_BIT: begin
                skip_c = |(opnd & bit_mask);
                two_cycle = 1'b1;
            end
            OP_SKIP_IF_NONZERO: begin
                mem_we = 1'b1;
                mem_wdata = opnd;
                skip_c = (opnd != 8'h00);
                two_cycle = 1'b1;
            end
            OP_SET_BYTE: begin
                mem_we = 1'b1;
                mem_wdata = BYTE_ONES;
            end
            OP_SET_BIT: begin
                mem_we = 1'b1;
                mem_wdata = opnd | bit_mask;
            end
            default: begin
                // Illegal codes and the no-op only advance the PC.
                mem_we = 1'b0;
            end
        endcase
    end

    wire exec = (state_reg == ST_EXEC);
    wire service = (state_reg == ST_SERVICE);
    wire is_interrupt_exit = (op_reg == OP_INTERRUPT_EXIT);
    wire [3:0] sp_top = sp_reg - 4'h1;
    wire [PC_W-1:0] pop_pc = stk[sp_top[2:0]];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one cycle, or a dummy second cycle for skips and returns, then a service cycle after an interrupt exit with a request pending.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (wr_cmd) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg <= two_cycle ? ST_DUMMY : ST_IDLE;
                end
                ST_DUMMY: begin
                    state_reg <= (is_interrupt_exit && irq_pending_i) ?
                        ST_SERVICE : ST_IDLE;
                end
                ST_SERVICE: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Command, address and immediate registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= OP_NOP;
            bit_reg <= 3'h0;
            addr_reg <= 4'h0;
            imm_reg <= 8'h00;
        end else begin
            if (wr_cmd) begin
                op_reg <= rssr_op_t'(wb_dat_i[4:0]);
                bit_reg <= wb_dat_i[CMD_BIT_LSB +: 3];
            end
            if (wr_addr) begin
                addr_reg <= wb_dat_i[3:0];
            end
            if (wr_imm) begin
                imm_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Accumulator, flags and global interrupt enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= ACC_RST;
            flags_reg <= FLAGS_RST;
            gie_reg <= 1'b0;
        end else if (exec) begin
            if (acc_we) begin
                acc_reg <= acc_wdata;
            end
            if (subf_we) begin
                flags_reg <= sub_flags;
            end else if (carry_we) begin
                flags_reg[FLAG_C] <= carry_wdata;
            end
            if (is_interrupt_exit) begin
                gie_reg <= 1'b1;
            end
        end else if (service) begin
            gie_reg <= 1'b0; // Entering the handler masks further requests.
        end else begin
            if (wr_acc) begin
                acc_reg <= wb_dat_i[7:0];
            end
            if (wr_flags) begin
                flags_reg <= wb_dat_i[5:0];
                gie_reg <= wb_dat_i[FLAG_GIE];
            end
        end
    end

    // Program counter and skip result.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= PC_RST;
            skip_reg <= 1'b0;
        end else if (exec) begin
            pc_reg <= pop_c ? pop_pc : pc_reg + 12'h001;
            skip_reg <= skip_c;
        end else if (state_reg == ST_DUMMY) begin
            if (skip_reg) begin
                pc_reg <= pc_reg + 12'h001;
            end
        end else if (service) begin
            pc_reg <= IRQ_VECTOR;
        end else if (wr_pc) begin
            pc_reg <= wb_dat_i[PC_W-1:0];
        end
    end

    // Return stack: software pushes, returns pop, interrupt entry pushes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_reg <= 4'h0;
        end else if (exec && pop_c && sp_reg != 4'h0) begin
            sp_reg <= sp_top;
        end else if ((wr_push || service) && sp_reg != 4'h8) begin
            sp_reg <= sp_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (service && sp_reg != 4'h8) begin
            stk[sp_reg[2:0]] <= pc_reg;
        end else if (wr_push && sp_reg != 4'h8) begin
            stk[sp_reg[2:0]] <= wb_dat_i[PC_W-1:0];
        end
    end

    // Data memory: the executing operation or the bus, never both.
    always_ff @(posedge clk_i) begin
        if (exec && mem_we) begin
            mem[addr_reg] <= mem_wdata;
        end else if (wr_mem) begin
            mem[mem_idx] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer, interrupt entry pulse and outputs.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            irq_taken_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            dat_reg <= (bus_req & ~ack_reg) ? rd_data : dat_reg;
            irq_taken_reg <= service;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_taken_o = irq_taken_reg;
    assign global_irq_enable_o = gie_reg;

endmodule

// >>> dv/rssr_exec_sva.sv
// Port checker for the rotate, subtract, skip and return unit.
`timescale 1ns/1ps
module rssr_exec_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_pending_i,
    input wire logic irq_taken_o,
    input wire logic global_irq_enable_o
);
    ////////////////////////////////////////
    // Cycles since the last acknowledged bus write, saturating at 15.
    logic [3:0] since_wr_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_wr_reg <= 4'hF;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            since_wr_reg <= 4'h0;
        end else if (since_wr_reg != 4'hF) begin
            since_wr_reg <= since_wr_reg + 4'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answers come one cycle after the request and last one cycle.
    chk_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
        !wb_ack_o && wb_adr_i[7] |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    // Interrupt hand-off after an exit with a request pending.
    chk_taken_pulse: assert property (irq_taken_o
        |=> !irq_taken_o) else $error("taken pulse too long");
    chk_taken_gie_low: assert property (irq_taken_o
        |-> !global_irq_enable_o) else $error("enable high while servicing");
    chk_taken_cause: assert property (irq_taken_o
        |-> $past(irq_pending_i, 2))
        else $error("taken without pending request");
    chk_gie_rise_cause: assert property (
        $rose(global_irq_enable_o) |-> since_wr_reg <= 4'h3)
        else $error("enable rose without command");
endmodule

// >>> dv/rssr_irq_src.sv
// Interrupt source model facing the unit.
`timescale 1ns/1ps
module rssr_irq_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raise_i,
    input wire logic irq_taken_i,
    output logic irq_pending_o
);
    ////////////////////////////////////////
    // A raised request stands until the unit reports it as taken.
    always_ff @(posedge clk_i) begin
        if (rst_i || irq_taken_i) begin
            irq_pending_o <= 1'b0;
        end else if (raise_i) begin
            irq_pending_o <= 1'b1;
        end
    end
endmodule

// >>> dv/rotate_subtract_skip_return_exec_tb_top.sv
// Self-checking bench for the rotate, subtract, skip and return unit.
`timescale 1ns/1ps
module rotate_subtract_skip_return_exec_tb_top;
    import rssr_pkg::*;
    localparam logic [7:0] MEM3 = 8'h4C;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_pending_i;
    logic irq_taken_o;
    logic global_irq_enable_o;
    logic raise = 1'b0;
    int checked = 0;
    int miscompares = 0;
    int taken_cnt = 0;

    ////////////////////////////////////////
    // Clock, unit and interrupt source.
    always #5 clk_i = ~clk_i;
    rssr_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_pending_i(irq_pending_i),
        .irq_taken_o(irq_taken_o),
        .global_irq_enable_o(global_irq_enable_o));
    rssr_irq_src partner (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
        .irq_taken_i(irq_taken_o), .irq_pending_o(irq_pending_i));

    // Count the service hand-offs seen at the port.
    always @(posedge clk_i) begin
        if (irq_taken_o === 1'b1) begin
            taken_cnt++;
        end
    end

    ////////////////////////////////////////
    // Verdict and end of run.
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    // One classic bus cycle, held until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] e,
                       input string s);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(s, e, q);
    endtask

    // Start an operation and poll until the unit is idle again.
    // Skips and returns must still be busy at the first poll.
    task automatic op(input rssr_op_t o, input logic [2:0] b);
        logic [31:0] q;
        logic [31:0] two;
        int n;
        two = {31'h0, (o >= OP_DECREMENT_SKIP_ZERO &&
            o <= OP_SKIP_IF_NONZERO) || (o >= OP_SUBROUTINE_EXIT &&
            o <= OP_INTERRUPT_EXIT)};
        wr(OFS_CMD, {24'h0, b, o});
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, q);
            if (n == 0) begin
                cmp("dummy", two, {31'h0, q[STAT_BUSY]});
            end
            n++;
        end while (q[STAT_BUSY] !== 1'b0 && n < 20);
        cmp("busy", 32'h0, {31'h0, q[STAT_BUSY]});
        if (q[STAT_BUSY] !== 1'b0) begin
            end_sim();
        end
    endtask

    // Load operands, run one operation, compare every visible result.
    task automatic run(input rssr_op_t o, input logic [2:0] b,
            input logic [7:0] a, m, f, ea, em, ef, input logic sk);
        wr(OFS_ADDR, {28'h0, MEM3[5:2]});
        wr(MEM3, {24'h0, m});
        wr(OFS_IMM, {24'h0, m});
        wr(OFS_ACC, {24'h0, a});
        wr(OFS_FLAGS, {24'h0, f});
        wr(OFS_PC, 32'h100);
        op(o, b);
        chk(OFS_ACC, {24'h0, ea}, "acc");
        chk(MEM3, {24'h0, em}, "mem");
        chk(OFS_FLAGS, {24'h0, ef}, "flags");
        chk(OFS_PC, 32'h101 + {31'h0, sk}, "pc");
    endtask

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [31:0] q;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(OFS_ACC, 32'h0, "acc reset");
        chk(OFS_PC, 32'h0, "pc reset");
        wr(8'h80, 32'hFF);
        chk(8'h80, 32'h0, "unmapped");
        run(OP_OR_INTO_MEMORY, 3'h0, 8'h51, 8'h0A, 8'h04, 8'h51, 8'h5B,
            8'h04, 1'b0);
        run(OP_ROTATE_LEFT_IN_PLACE, 3'h0, 8'h00, 8'h97, 8'h04, 8'h00,
            8'h2F, 8'h04, 1'b0);
        run(OP_ROTATE_LEFT_TO_WORKING, 3'h0, 8'h00, 8'h97, 8'h04, 8'h2F,
            8'h97, 8'h04, 1'b0);
        run(OP_ROTATE_LEFT_VIA_FLAG, 3'h0, 8'h00, 8'h97, 8'h04, 8'h00,
            8'h2E, 8'h05, 1'b0);
        run(OP_ROTATE_LEFT_VIA_FLAG_TO_WORKING, 3'h0, 8'h00, 8'h97, 8'h04,
            8'h2E, 8'h97, 8'h05, 1'b0);
        run(OP_ROTATE_RIGHT_IN_PLACE, 3'h0, 8'h00, 8'h97, 8'h04, 8'h00,
            8'hCB, 8'h04, 1'b0);
        run(OP_ROTATE_RIGHT_TO_WORKING, 3'h0, 8'h00, 8'h97, 8'h04, 8'hCB,
            8'h97, 8'h04, 1'b0);
        run(OP_ROTATE_RIGHT_VIA_FLAG, 3'h0, 8'h00, 8'h97, 8'h04, 8'h00,
            8'h4B, 8'h05, 1'b0);
        run(OP_ROTATE_RIGHT_VIA_FLAG_TO_WORKING, 3'h0, 8'h00, 8'h97, 8'h04,
            8'h4B, 8'h97, 8'h05, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW, 3'h0, 8'h10, 8'h20, 8'h01, 8'hF0,
            8'h20, 8'h12, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW_IMM, 3'h0, 8'h80, 8'h00, 8'h04, 8'h7F,
            8'h00, 8'h19, 1'b0);
        run(OP_SUBTRACT_WITH_BORROW_TO_MEMORY, 3'h0, 8'h35, 8'h34, 8'h04,
            8'h35, 8'h00, 8'h27, 1'b0);
        run(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h5A, 8'h01, 8'h15, 8'h5A,
            8'h00, 8'h15, 1'b1);
        run(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h5A, 8'h05, 8'h15, 8'h5A,
            8'h04, 8'h15, 1'b0);
        run(OP_DECREMENT_SKIP_ZERO_TO_WORKING, 3'h0, 8'h5A, 8'h01, 8'h15,
            8'h00, 8'h01, 8'h15, 1'b1);
        run(OP_INCREMENT_SKIP_ZERO, 3'h0, 8'h5A, 8'hFF, 8'h15, 8'h5A,
            8'h00, 8'h15, 1'b1);
        run(OP_INCREMENT_SKIP_ZERO_TO_WORKING, 3'h0, 8'h5A, 8'h10, 8'h15,
            8'h11, 8'h10, 8'h15, 1'b0);
        run(OP_SKIP_IF_NONZERO_BIT, 3'h3, 8'h5A, 8'h08, 8'h15, 8'h5A,
            8'h08, 8'h15, 1'b1);
        run(OP_SKIP_IF_NONZERO_BIT, 3'h2, 8'h5A, 8'hFB, 8'h15, 8'h5A,
            8'hFB, 8'h15, 1'b0);
        run(OP_SKIP_IF_NONZERO, 3'h0, 8'h5A, 8'h00, 8'h15, 8'h5A, 8'h00,
            8'h15, 1'b0);
        run(OP_SKIP_IF_NONZERO, 3'h0, 8'h5A, 8'h40, 8'h15, 8'h5A, 8'h40,
            8'h15, 1'b1);
        run(OP_SET_BYTE, 3'h0, 8'h5A, 8'h12, 8'h15, 8'h5A, 8'hFF, 8'h15,
            1'b0);
        run(OP_SET_BIT, 3'h7, 8'h5A, 8'h41, 8'h15, 8'h5A, 8'hC1, 8'h15,
            1'b0);
        wr(OFS_PUSH, 32'h234);
        op(OP_SUBROUTINE_EXIT, 3'h0);
        chk(OFS_PC, 32'h234, "pc");
        chk(OFS_FLAGS, 32'h15, "flags");
        wr(OFS_PUSH, 32'h345);
        wr(OFS_IMM, 32'hA7);
        op(OP_SUBROUTINE_EXIT_IMM, 3'h0);
        chk(OFS_PC, 32'h345, "pc");
        chk(OFS_ACC, 32'hA7, "acc");
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_PUSH, 32'h56);
        op(OP_INTERRUPT_EXIT, 3'h0);
        chk(OFS_PC, 32'h56, "pc");
        cmp("gie", 32'h1, {31'h0, global_irq_enable_o});
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_PUSH, 32'h67);
        @(posedge clk_i);
        raise <= 1'b1;
        @(posedge clk_i);
        raise <= 1'b0;
        op(OP_INTERRUPT_EXIT, 3'h0);
        chk(OFS_PC, {20'h0, IRQ_VECTOR}, "pc");
        cmp("taken", 32'h1, taken_cnt);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        cmp("depth", 32'h10, q & 32'hF0);
        op(OP_SUBROUTINE_EXIT, 3'h0);
        chk(OFS_PC, 32'h67, "pc");
        end_sim();
    end
endmodule

bind rssr_exec rssr_exec_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_pending_i(irq_pending_i), .irq_taken_o(irq_taken_o),
    .global_irq_enable_o(global_irq_enable_o));
